/* File: hdl/scc_fifo_consts.svh */
// offsets, field positions, response codes and counts of the serial channel fifo block
`ifndef SCC_FIFO_CONSTS_SVH
`define SCC_FIFO_CONSTS_SVH
`define OFF_CONFIG      8'h00
`define OFF_THRESHOLD   8'h04
`define OFF_BAUD_LO     8'h08
`define OFF_BAUD_HI     8'h0C
`define OFF_COMMAND     8'h10
`define OFF_ISR_SECOND  8'h14
`define OFF_STATUS      8'h18
`define OFF_TX_DATA     8'h1C
`define OFF_RX_DATA     8'h20
`define OFF_RX_WORD     8'h24
`define OFF_TIMER       8'h28
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ISR_UNDERRUN    0
`define ISR_OVERFLOW    1
`define ISR_FRAME_LOST  2
`define ISR_THRESHOLD   3
`define CMD_RX_RESET    0
`define RECEIVE_STATUS_BYTE_OVF_BIT    7
`define RECEIVE_STATUS_BYTE_ABORT_BIT  6
`define THR_CHAR_DEF    7'h01
`define THR_SEL1        7'h04
`define THR_SEL2        7'h10
`define THR_FRAME_DEF   7'h20
`define DIV16_LAST      4'hF
`define DPLL_REALIGN    4'h8
`define MAJ_S0          4'h7
`define MAJ_S1          4'h8
`define MAJ_S2          4'h9
`define STAT_SH_POS     8
`define STAT_RX_POS     16
`define STAT_BLOCK_BIT  24
`define STAT_DISC_BIT   25
`endif

/* File: hdl/scc_fifo_pkg.sv */
// types of the serial channel fifo block
package scc_fifo_pkg;
  typedef struct packed {
    logic       big_endian;
    logic       char_mode;
    logic       bit_clock_rate;
    logic       transmit_clock_output_enable;
    logic       source_select;
    logic [2:0] clock_mode_field;
    logic       channel_power_up;
  } cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       frame_end;
    logic       frame_abort;
  } rx_in_t;
endpackage

/* File: hdl/scc_fifo.sv */
// serial channel fifos, clock selection and register slave
// Function
// [RULE1] transmit buffer is a host pool plus a shadow pool, 32 bytes each
// [RULE2] host transmit pool accepts data while the channel is powered down
// [RULE3] after underrun, refuse host data and stop feeding the transmitter
// [RULE4] reading the second interrupt status register releases underrun blocking
// [RULE5] bytes move to shadow pool only when powered up with valid transmit clock
// [RULE6] transmission starts with a shadow byte and the mode's transmit enable
// [RULE7] receive buffer is two 32 byte pools between receive clock and host
// [RULE8] receive request raised when fill level reaches the selected threshold
// [RULE9] default threshold is 32 bytes in frame modes, 1 in character modes
// [RULE10] a full receive buffer discards data and flags overflow
// [RULE11] storing resumes after frame end or abort once space exists
// [RULE12] the affected frame's status byte carries the overflow indication
// [RULE13] each entirely discarded frame raises a frame lost event
// [RULE14] receiver reset command clears the receive buffer
// [RULE15] a partly delivered frame stays open across receiver reset
// [RULE16] fourteen clock modes chosen by the clock mode field
// [RULE17] transmit clock pin drives out in certain modes when enabled
// [RULE18] the phase locked loop is clocked by the channel baud generator
// [RULE19] baud divisor set through low and high baud registers
// [RULE20] internal timer runs on the internal transmit clock
// [RULE21] separate internal transmit and receive clocks drive the protocol machines
// [RULE22] clock mode picked by mode field plus source select bit
// [RULE23] rate 16 in async takes three samples and a majority decision
// [RULE24] 16 bit buffer accesses order bytes by selected endianness
`timescale 1ns/100ps
`default_nettype none
`include "scc_fifo_consts.svh"
module scc_fifo #(
  parameter int POOL = 32
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire scc_fifo_pkg::rx_in_t  rx_in,
  input  wire logic                  receive_clock_pin,
  input  wire logic                  transmit_clock_pin_in,
  output logic                       transmit_clock_pin_out,
  output logic                       transmit_clock_pin_oe,
  input  wire logic                  rxd,
  input  wire logic                  cts_n,
  input  wire logic                  tx_gate,
  input  wire logic                  ts_valid_tx,
  output logic [7:0]                 tx_byte,
  output logic                       tx_byte_strobe,
  output logic                       rec_clk_tick,
  output logic                       trm_clk_tick,
  output logic                       rx_bit,
  output logic                       rx_request
);
  localparam int TW = $clog2(POOL) + 1;
  localparam int RW = $clog2(2 * POOL) + 1;
  localparam logic [TW-1:0] TX_FULL = TW'(POOL);
  localparam logic [RW-1:0] RX_FULL = RW'(2 * POOL);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  scc_fifo_pkg::cfg_t cfg_reg;
  logic [1:0]  thr_field_reg;
  logic [7:0]  baud_lo_reg, baud_hi_reg;
  logic [3:0]  isr_reg;
  logic [15:0] timer_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_ok_reg, w_ok_reg;
  logic        do_wr, ar_hs, isr_rd, rx_rst, wr_tx, rd_rx1, rd_rx2;
  logic [31:0] rd_data;
  logic [1:0]  rd_resp;

  assign do_wr  = aw_ok_reg && w_ok_reg && !s_axi_bvalid;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign isr_rd = ar_hs && s_axi_araddr == `OFF_ISR_SECOND;
  assign rd_rx1 = ar_hs && s_axi_araddr == `OFF_RX_DATA;
  assign rd_rx2 = ar_hs && s_axi_araddr == `OFF_RX_WORD;
  assign wr_tx  = do_wr && aw_addr_reg == `OFF_TX_DATA;
  assign rx_rst = do_wr && aw_addr_reg == `OFF_COMMAND && w_data_reg[`CMD_RX_RESET]; // RULE14

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_ok_reg     <= 1'b0;
      w_ok_reg      <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_ok_reg     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_ok_reg     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_ok_reg    <= 1'b0;
        w_ok_reg     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > `OFF_TIMER) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg       <= '0;
      thr_field_reg <= 2'h0;
      baud_lo_reg   <= 8'h00;
      baud_hi_reg   <= 8'h00;
    end else if (do_wr && w_strb_reg[0]) begin
      case (aw_addr_reg)
        `OFF_CONFIG:    cfg_reg <= w_data_reg[$bits(scc_fifo_pkg::cfg_t)-1:0]; // RULE16 RULE22
        `OFF_THRESHOLD: thr_field_reg <= w_data_reg[1:0];
        `OFF_BAUD_LO:   baud_lo_reg <= w_data_reg[7:0]; // RULE19
        `OFF_BAUD_HI:   baud_hi_reg <= w_data_reg[7:0]; // RULE19
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // clock selection
  // ----------------------------------------
  logic        rxc_q, txc_q, rxd_q, rx_edge, tx_edge, rxd_edge;
  logic        brg_src, brg_tick, b16_tick, dpll_tick, rec_raw, trm_raw, rec_tick, trm_tick;
  logic        bcr_on, rdiv, tdiv, toe_mode, tx_en, maj_s0, maj_s1, tx_clk_ok_reg;
  logic [15:0] brg_cnt;
  logic [3:0]  b16_cnt, dp_cnt, rc_cnt, tc_cnt;
  logic [2:0]  cm;
  logic        ss;

  assign cm       = cfg_reg.clock_mode_field;
  assign ss       = cfg_reg.source_select;
  assign rx_edge  = receive_clock_pin && !rxc_q;
  assign tx_edge  = transmit_clock_pin_in && !txc_q;
  assign rxd_edge = rxd ^ rxd_q;
  assign brg_src  = (cm == 3'h2 || cm == 3'h3) ? rx_edge : 1'b1;
  assign brg_tick = brg_src && brg_cnt == 16'h0000;
  assign b16_tick = brg_tick && b16_cnt == `DIV16_LAST;
  assign dpll_tick = brg_tick && dp_cnt == `DIV16_LAST && !rxd_edge; // RULE18
  assign bcr_on   = cfg_reg.char_mode && cfg_reg.bit_clock_rate;
  assign rdiv     = bcr_on && (cm <= 3'h1 || ((cm == 3'h3 || cm == 3'h7) && ss));
  assign tdiv     = bcr_on && (cm == 3'h1 || ((cm == 3'h3 || cm == 3'h7) && ss));
  assign rec_tick = rdiv ? (rec_raw && rc_cnt == `DIV16_LAST) : rec_raw;
  assign trm_tick = tdiv ? (trm_raw && tc_cnt == `DIV16_LAST) : trm_raw;

  always_comb begin
    rec_raw  = rx_edge;
    trm_raw  = tx_edge;
    toe_mode = 1'b0;
    tx_en    = !cts_n;
    case (cm) // RULE16 RULE22
      3'h0: begin
        trm_raw  = ss ? brg_tick : tx_edge;
        toe_mode = ss;
      end
      3'h1: begin
        trm_raw = rx_edge;
        tx_en   = transmit_clock_pin_in;
      end
      3'h2, 3'h6: begin
        rec_raw  = dpll_tick;
        trm_raw  = ss ? b16_tick : tx_edge;
        toe_mode = ss;
      end
      3'h3, 3'h7: begin
        rec_raw  = ss ? brg_tick : dpll_tick;
        trm_raw  = ss ? brg_tick : dpll_tick;
        toe_mode = 1'b1;
      end
      3'h4: tx_en = !tx_gate;
      3'h5: begin
        trm_raw  = ss ? tx_edge : rx_edge;
        toe_mode = !ss;
        tx_en    = ts_valid_tx;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxc_q   <= 1'b0;
      txc_q   <= 1'b0;
      rxd_q   <= 1'b1;
      brg_cnt <= 16'h0000;
      b16_cnt <= 4'h0;
      dp_cnt  <= 4'h0;
    end else begin
      rxc_q <= receive_clock_pin;
      txc_q <= transmit_clock_pin_in;
      rxd_q <= rxd;
      if (brg_src)
        brg_cnt <= (brg_cnt == 16'h0000) ? {baud_hi_reg, baud_lo_reg} : brg_cnt - 16'h0001; // RULE19
      if (brg_tick)
        b16_cnt <= b16_cnt + 4'h1;
      if (rxd_edge)
        dp_cnt <= `DPLL_REALIGN;
      else if (brg_tick)
        dp_cnt <= dp_cnt + 4'h1; // RULE18
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rc_cnt       <= 4'h0;
      tc_cnt       <= 4'h0;
      maj_s0       <= 1'b0;
      maj_s1       <= 1'b0;
      rx_bit       <= 1'b0;
      rec_clk_tick <= 1'b0;
      trm_clk_tick <= 1'b0;
      timer_reg    <= 16'h0000;
    end else begin
      rec_clk_tick <= rec_tick; // RULE21
      trm_clk_tick <= trm_tick; // RULE21
      if (rec_raw)
        rc_cnt <= rc_cnt + 4'h1;
      if (trm_raw)
        tc_cnt <= tc_cnt + 4'h1;
      if (rdiv && rec_raw) begin // RULE23
        if (rc_cnt == `MAJ_S0)
          maj_s0 <= rxd;
        if (rc_cnt == `MAJ_S1)
          maj_s1 <= rxd;
        if (rc_cnt == `MAJ_S2)
          rx_bit <= (maj_s0 & maj_s1) | (maj_s0 & rxd) | (maj_s1 & rxd);
      end else if (!rdiv && rec_tick) begin
        rx_bit <= rxd;
      end
      if (do_wr && aw_addr_reg == `OFF_TIMER)
        timer_reg <= 16'h0000;
      else if (trm_tick)
        timer_reg <= timer_reg + 16'h0001; // RULE20
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe  <= 1'b0;
    end else begin
      transmit_clock_pin_oe <= cfg_reg.transmit_clock_output_enable && toe_mode; // RULE17
      if (cm == 3'h5)
        transmit_clock_pin_out <= ts_valid_tx;
      else if (trm_tick)
        transmit_clock_pin_out <= !transmit_clock_pin_out; // RULE17
    end
  end

  // ----------------------------------------
  // transmit pools
  // ----------------------------------------
  logic [7:0]    hp_mem [POOL];
  logic [7:0]    sh_mem [POOL];
  logic [TW-1:0] hp_wp, hp_rp, sh_wp, sh_rp, hp_cnt, sh_cnt, tx_n;
  logic          tx_block_reg, tx_active_reg, tx_push, tx_move, tx_pop, ur_ev;
  logic [7:0]    tx_b0, tx_b1;

  assign hp_cnt  = hp_wp - hp_rp;
  assign sh_cnt  = sh_wp - sh_rp;
  assign tx_n    = TW'(w_strb_reg[0]) + TW'(w_strb_reg[1]);
  assign tx_push = wr_tx && !tx_block_reg && hp_cnt + tx_n <= TX_FULL; // RULE2 RULE3
  assign tx_move = cfg_reg.channel_power_up && tx_clk_ok_reg && !tx_block_reg
                   && hp_cnt != '0 && sh_cnt != TX_FULL; // RULE5 RULE1
  assign tx_pop  = trm_tick && tx_en && !tx_block_reg && sh_cnt != '0; // RULE6
  assign ur_ev   = trm_tick && tx_en && !tx_block_reg && tx_active_reg && sh_cnt == '0;
  assign tx_b0   = cfg_reg.big_endian ? (w_strb_reg[1] ? w_data_reg[15:8] : w_data_reg[7:0])
                                      : (w_strb_reg[0] ? w_data_reg[7:0] : w_data_reg[15:8]); // RULE24
  assign tx_b1   = cfg_reg.big_endian ? w_data_reg[7:0] : w_data_reg[15:8]; // RULE24

  always_ff @(posedge clk_sys) begin
    if (tx_push) begin
      hp_mem[hp_wp[TW-2:0]] <= tx_b0;
      if (tx_n == TW'(2))
        hp_mem[hp_wp[TW-2:0] + (TW-1)'(1)] <= tx_b1;
    end
    if (tx_move)
      sh_mem[sh_wp[TW-2:0]] <= hp_mem[hp_rp[TW-2:0]];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hp_wp          <= '0;
      hp_rp          <= '0;
      sh_wp          <= '0;
      sh_rp          <= '0;
      tx_block_reg   <= 1'b0;
      tx_active_reg  <= 1'b0;
      tx_clk_ok_reg  <= 1'b0;
      tx_byte        <= 8'h00;
      tx_byte_strobe <= 1'b0;
    end else begin
      tx_byte_strobe <= tx_pop;
      if (tx_push)
        hp_wp <= hp_wp + tx_n;
      if (tx_move) begin
        hp_rp <= hp_rp + TW'(1);
        sh_wp <= sh_wp + TW'(1);
      end
      if (tx_pop) begin
        sh_rp   <= sh_rp + TW'(1);
        tx_byte <= sh_mem[sh_rp[TW-2:0]];
      end
      tx_clk_ok_reg <= cfg_reg.channel_power_up && (tx_clk_ok_reg || trm_tick);
      tx_active_reg <= cfg_reg.channel_power_up && !ur_ev && (tx_active_reg || tx_pop);
      if (ur_ev)
        tx_block_reg <= 1'b1; // RULE3
      else if (isr_rd)
        tx_block_reg <= 1'b0; // RULE4
    end
  end

  // ----------------------------------------
  // receive pools
  // ----------------------------------------
  logic [7:0]    rx_mem [2*POOL];
  logic [RW-1:0] rx_wp, rx_rp, rx_cnt, rx_npop, thr;
  logic          rx_full, is_end, rx_push, ovf_ev, lost_ev, thr_ev;
  logic          discard_reg, stored_reg;
  logic [7:0]    rx_wbyte, rx_b0, rx_b1;

  assign rx_cnt  = rx_wp - rx_rp;
  assign rx_full = rx_cnt == RX_FULL;
  assign is_end  = rx_in.frame_end || rx_in.frame_abort;
  assign ovf_ev  = !discard_reg && rx_full && (is_end || rx_in.valid); // RULE10
  assign lost_ev = is_end && discard_reg && !stored_reg; // RULE13
  assign rx_b0   = rx_mem[rx_rp[RW-2:0]];
  assign rx_b1   = rx_mem[rx_rp[RW-2:0] + (RW-1)'(1)];
  assign rx_npop = (rd_rx2 && rx_cnt > RW'(1)) ? RW'(2) : ((rd_rx1 || rd_rx2) && rx_cnt != '0) ? RW'(1) : '0;
  assign thr_ev  = !rx_request && rx_cnt >= thr;

  always_comb begin
    rx_push  = 1'b0;
    rx_wbyte = rx_in.data;
    if (is_end) begin
      rx_wbyte = 8'h00;
      rx_wbyte[`RECEIVE_STATUS_BYTE_OVF_BIT]   = discard_reg; // RULE12
      rx_wbyte[`RECEIVE_STATUS_BYTE_ABORT_BIT] = rx_in.frame_abort;
      rx_push  = !rx_full && (!discard_reg || stored_reg); // RULE11
    end else begin
      rx_push = rx_in.valid && !discard_reg && !rx_full; // RULE7
    end
  end

  always_comb begin
    case (thr_field_reg) // RULE8
      2'h0:    thr = cfg_reg.char_mode ? `THR_CHAR_DEF : `THR_FRAME_DEF; // RULE9
      2'h1:    thr = `THR_SEL1;
      2'h2:    thr = `THR_SEL2;
      default: thr = `THR_FRAME_DEF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rx_push)
      rx_mem[rx_wp[RW-2:0]] <= rx_wbyte;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_wp       <= '0;
      rx_rp       <= '0;
      discard_reg <= 1'b0;
      stored_reg  <= 1'b0;
      rx_request  <= 1'b0;
    end else begin
      rx_request <= rx_cnt >= thr; // RULE8
      if (rx_rst) begin
        rx_wp       <= '0; // RULE14
        rx_rp       <= '0;
        discard_reg <= 1'b0; // RULE15
      end else begin
        if (rx_push)
          rx_wp <= rx_wp + RW'(1);
        rx_rp <= rx_rp + rx_npop;
        if (ovf_ev)
          discard_reg <= 1'b1; // RULE10
        else if (is_end && discard_reg && !rx_full)
          discard_reg <= 1'b0; // RULE11
      end
      if (is_end)
        stored_reg <= 1'b0;
      else if (rx_push)
        stored_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // read path and status
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    case (s_axi_araddr)
      `OFF_CONFIG:     rd_data[$bits(scc_fifo_pkg::cfg_t)-1:0] = cfg_reg;
      `OFF_THRESHOLD:  rd_data[1:0] = thr_field_reg;
      `OFF_BAUD_LO:    rd_data[7:0] = baud_lo_reg;
      `OFF_BAUD_HI:    rd_data[7:0] = baud_hi_reg;
      `OFF_COMMAND:    rd_data = 32'h0000_0000;
      `OFF_ISR_SECOND: rd_data[3:0] = isr_reg;
      `OFF_STATUS: begin
        rd_data[TW-1:0] = hp_cnt;
        rd_data[`STAT_SH_POS +: TW] = sh_cnt;
        rd_data[`STAT_RX_POS +: RW] = rx_cnt;
        rd_data[`STAT_BLOCK_BIT] = tx_block_reg;
        rd_data[`STAT_DISC_BIT] = discard_reg;
      end
      `OFF_TX_DATA:    rd_data = 32'h0000_0000;
      `OFF_RX_DATA:    rd_data[7:0] = (rx_cnt != '0) ? rx_b0 : 8'h00;
      `OFF_RX_WORD: begin
        if (rx_npop == RW'(2))
          rd_data[15:0] = cfg_reg.big_endian ? {rx_b0, rx_b1} : {rx_b1, rx_b0}; // RULE24
        else if (rx_npop == RW'(1))
          rd_data[15:0] = cfg_reg.big_endian ? {rx_b0, 8'h00} : {8'h00, rx_b0};
      end
      `OFF_TIMER:      rd_data[15:0] = timer_reg;
      default:         rd_resp = `RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
      isr_reg       <= 4'h0;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      isr_reg <= (isr_rd ? 4'h0 : isr_reg) | {thr_ev, lost_ev, ovf_ev, ur_ev}; // RULE4
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_block_refuse;
    tx_block_reg && wr_tx |=> hp_cnt == $past(hp_cnt);
  endproperty
  a_block_refuse: assert property (p_block_refuse) else $error("host data taken while blocked"); // RULE3
  property p_block_stop;
    tx_block_reg && !isr_rd |=> !tx_byte_strobe ##1 !tx_byte_strobe;
  endproperty
  a_block_stop: assert property (p_block_stop) else $error("byte sent while blocked"); // RULE3
  property p_release;
    isr_rd && !ur_ev |=> !tx_block_reg;
  endproperty
  a_release: assert property (p_release) else $error("underrun block not released"); // RULE4
  property p_move_pu;
    sh_wp != $past(sh_wp) |-> $past(cfg_reg.channel_power_up) && $past(tx_clk_ok_reg);
  endproperty
  a_move_pu: assert property (p_move_pu) else $error("shadow filled while powered down"); // RULE5
  property p_pd_accept;
    wr_tx && !cfg_reg.channel_power_up && !tx_block_reg && hp_cnt == '0 && w_strb_reg[0] |=> hp_cnt != '0;
  endproperty
  a_pd_accept: assert property (p_pd_accept) else $error("powered down write lost"); // RULE2
  property p_overflow;
    rx_in.valid && !is_end && rx_full && !discard_reg && !rx_rst |=> discard_reg && isr_reg[`ISR_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // RULE10
  property p_rx_reset;
    rx_rst |=> rx_cnt == '0 && !discard_reg;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receive buffer not cleared"); // RULE14
  property p_dpll;
    dp_cnt != $past(dp_cnt) |-> $past(brg_tick) || $past(rxd_edge);
  endproperty
  a_dpll: assert property (p_dpll) else $error("dpll stepped without baud tick"); // RULE18
  property p_thr;
    rx_cnt >= thr && !rx_rst ##1 rx_cnt >= thr |-> rx_request;
  endproperty
  a_thr: assert property (p_thr) else $error("receive request missing"); // RULE8
  property p_lost;
    lost_ev |=> isr_reg[`ISR_FRAME_LOST];
  endproperty
  a_lost: assert property (p_lost) else $error("frame lost not flagged"); // RULE13

  c_underrun: cover property (ur_ev ##[1:50] isr_rd);
  c_overflow: cover property (ovf_ev ##[1:200] (is_end && discard_reg && !rx_full));
  c_lost: cover property (lost_ev);
endmodule
`default_nettype wire

/* File: bench/rx_side_model.sv */
// serial side model: clock pins and receive protocol byte stream
`timescale 1ns/100ps
`default_nettype none
module rx_side_model (
  input  wire logic          clk_sys,
  input  wire logic          clk_en,
  output scc_fifo_pkg::rx_in_t rx_in,
  output logic               rx_clk_pin,
  output logic               tx_clk_pin
);
  logic [2:0] div_reg;
  // ----------------------------------------
  // clock pins, still while disabled
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (clk_en) begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign rx_clk_pin = div_reg[2];
  assign tx_clk_pin = div_reg[1];
  initial begin
    div_reg = 3'h0;
    rx_in = '0;
  end
  // one byte pulse, idle data inverted afterwards
  task automatic send(input logic [7:0] b, input logic fe);
    @(posedge clk_sys);
    rx_in <= '{1'b1, b, fe, 1'b0};
    @(posedge clk_sys);
    rx_in <= '{1'b0, ~b, 1'b0, 1'b0};
  endtask
endmodule
`default_nettype wire

/* File: bench/scc_fifo_test.sv */
// self-checking bench of the serial channel fifo block
`timescale 1ns/100ps
`default_nettype none
`include "scc_fifo_consts.svh"
module scc_fifo_test;
  logic clk_sys = 0, rst_n = 0, en = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awr, wr_, bv, arr, rv, rxp, txp, rq, rb;
  logic [31:0] wdata = 32'h00000000, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] tb;
  scc_fifo_pkg::rx_in_t rx_in;
  int n_errors = 0, checks = 0;
  bit wrr[5] = '{0, 1, 0, 0, 1};
  logic [7:0] ad[5] = '{8'h18, 8'h1C, 8'h18, 8'h2C, 8'h30};
  logic [31:0] dt[5] = '{32'h00000000, 32'h00000A55, 32'h00000002, 32'h00000000, 32'h00000000};
  logic [1:0] rsx[5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
  always #2 clk_sys = ~clk_sys;
  scc_fifo i_scc_fifo (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .rx_in(rx_in), .receive_clock_pin(rxp),
    .transmit_clock_pin_in(txp), .transmit_clock_pin_out(), .transmit_clock_pin_oe(), .rxd(1'b1),
    .cts_n(1'b0), .tx_gate(1'b0), .ts_valid_tx(1'b1), .tx_byte(tb), .tx_byte_strobe(), .rec_clk_tick(),
    .trm_clk_tick(), .rx_bit(rb), .rx_request(rq));
  rx_side_model i_rx_side_model (.clk_sys(clk_sys), .clk_en(en), .rx_in(rx_in), .rx_clk_pin(rxp),
    .tx_clk_pin(txp));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: hold each channel until its own handshake, sampled between edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ah, wh, bh;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge clk_sys);
      ah = awr && awvalid; wh = wr_ && wvalid; bh = bv && bready; r = bresp;
      @(posedge clk_sys);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
      n++;
    end while (!bh && n < 100);
    if (!bh) chk("write timeout", 32'h0, 32'h1);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ah, dh;
    n = 0;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge clk_sys);
      ah = arr && arvalid; dh = rv && rready; d = rdata; r = rresp;
      @(posedge clk_sys);
      if (ah) arvalid <= 0;
      if (dh) rready <= 0;
      n++;
    end while (!dh && n < 100);
    if (!dh) chk("read timeout", 32'h0, 32'h1);
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    en <= 1;
    for (int i = 0; i < 5; i++) begin
      if (wrr[i]) wr(ad[i], dt[i], rs);
      else rdr(ad[i], rd, rs);
      chk("resp", {30'h0, rsx[i]}, {30'h0, rs});
      if (!wrr[i]) chk("rdata", dt[i], rd);
    end
    wr(`OFF_CONFIG, 32'h00000080, rs);
    i_rx_side_model.send(8'h11, 1'b0);
    i_rx_side_model.send(8'h22, 1'b0);
    rdr(`OFF_STATUS, rd, rs);
    chk("rx count", 32'h2, {25'h0, rd[22:16]});
    chk("rx request", 32'h1, {31'h0, rq});
    rdr(`OFF_RX_WORD, rd, rs);
    chk("rx word", 32'h2211, {16'h0, rd[15:0]});
    @(negedge clk_sys);
    chk("rx request empty", 32'h0, {31'h0, rq});
    i_rx_side_model.send(8'h33, 1'b0);
    wr(`OFF_COMMAND, 32'h00000001, rs);
    rdr(`OFF_STATUS, rd, rs);
    chk("rx count reset", 32'h0, {25'h0, rd[22:16]});
    repeat (65) i_rx_side_model.send(8'h5A, 1'b0);
    rdr(`OFF_STATUS, rd, rs);
    chk("rx count full", 32'h40, {25'h0, rd[22:16]});
    rdr(`OFF_ISR_SECOND, rd, rs);
    chk("overflow flag", 32'h1, {31'h0, rd[`ISR_OVERFLOW]});
    rdr(`OFF_ISR_SECOND, rd, rs);
    chk("overflow cleared", 32'h0, {31'h0, rd[`ISR_OVERFLOW]});
    chk("rx bit", 32'h1, {31'h0, rb});
    wr(`OFF_CONFIG, 32'h00000081, rs);
    repeat (40) @(posedge clk_sys);
    chk("tx byte", 32'h0A, {24'h0, tb});
    rdr(`OFF_STATUS, rd, rs);
    chk("tx blocked", 32'h1, {31'h0, rd[`STAT_BLOCK_BIT]});
    wr(`OFF_TX_DATA, 32'h00001234, rs);
    rdr(`OFF_STATUS, rd, rs);
    chk("tx refused", 32'h0, {18'h0, rd[13:0]});
    rdr(`OFF_ISR_SECOND, rd, rs);
    chk("underrun flag", 32'h1, {31'h0, rd[`ISR_UNDERRUN]});
    rdr(`OFF_STATUS, rd, rs);
    chk("tx released", 32'h0, {31'h0, rd[`STAT_BLOCK_BIT]});
    finish_test();
  end
endmodule
`default_nettype wire
